/* File: design/rtc_pkg.sv */
// shared constants and carrier types for the rtc update core
package rtc_pkg;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] dom;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } time_t;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } alarm_t;

    typedef struct packed {
        logic       subtract;
        logic [5:0] count;
    } trim_t;

    // ------------------------------------------------------------
    // reset values of time, calendar and alarm
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_RST   = 8'h00;
    localparam logic [7:0] MIN_RST   = 8'h00;
    localparam logic [7:0] HOUR_RST  = 8'h00;
    localparam logic [7:0] DOW_RST   = 8'h01;
    localparam logic [7:0] DOM_RST   = 8'h01;
    localparam logic [7:0] MONTH_RST = 8'h01;
    localparam logic [7:0] YEAR_RST  = 8'h00;
    localparam logic [7:0] ALARM_RST = 8'h00;

    // ------------------------------------------------------------
    // counting limits (binary, 24 hour)
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_MAX   = 8'h3b;
    localparam logic [7:0] MIN_MAX   = 8'h3b;
    localparam logic [7:0] HOUR_MAX  = 8'h17;
    localparam logic [7:0] DOW_MAX   = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h0c;
    localparam logic [7:0] YEAR_MAX  = 8'h63;
    localparam logic [7:0] FEB       = 8'h02;
    localparam logic [7:0] APR       = 8'h04;
    localparam logic [7:0] JUN       = 8'h06;
    localparam logic [7:0] SEP       = 8'h09;
    localparam logic [7:0] NOV       = 8'h0b;
    localparam logic [7:0] DAYS_31   = 8'h1f;
    localparam logic [7:0] DAYS_30   = 8'h1e;
    localparam logic [7:0] DAYS_29   = 8'h1d;
    localparam logic [7:0] DAYS_28   = 8'h1c;

    // ------------------------------------------------------------
    // flag register layout
    // ------------------------------------------------------------
    localparam int UDF_BIT  = 4;
    localparam int AMF_BIT  = 5;
    localparam int COMBINED_REQUEST_FLAG_BIT = 7;

    // ------------------------------------------------------------
    // second length in slow clock periods
    // ------------------------------------------------------------
    localparam logic [15:0] SECOND_NOMINAL = 16'h8000;
    localparam logic [15:0] SECOND_SHORT   = 16'h7fff;
    localparam logic [15:0] SECOND_LONG    = 16'h8001;

    // ------------------------------------------------------------
    // timing, in slow clock periods of 32768 Hz
    // ------------------------------------------------------------
    localparam longint SLOW_HZ       = 64'd32768;
    localparam longint NS_PER_S      = 64'd1000000000;
    localparam longint LEAD_NS       = 64'd244100;
    localparam longint SETTLE_NS     = 64'd30500;
    // least times, so rounded up
    localparam longint LEAD_SLOW_L   =
        (LEAD_NS * SLOW_HZ + NS_PER_S - 1) / NS_PER_S;
    localparam longint SETTLE_SLOW_L =
        (SETTLE_NS * SLOW_HZ + NS_PER_S - 1) / NS_PER_S;
    localparam logic [15:0] LEAD_SLOW   = LEAD_SLOW_L[15:0];
    localparam logic [15:0] SETTLE_SLOW =
        (SETTLE_SLOW_L < 1) ? 16'h0001 : SETTLE_SLOW_L[15:0];

    typedef enum logic [1:0] {
        ST_COUNT,
        ST_LEAD,
        ST_SETTLE
    } upd_state_t;

endpackage

/* File: design/calendar_advance.sv */
// one-second advance of the time and calendar, with cascaded carries
`timescale 1ns/1ps
module calendar_advance
    import rtc_pkg::*;
(
    input  rtc_pkg::time_t cur,
    output rtc_pkg::time_t nxt
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] wrap_inc(
        input logic [7:0] v,
        input logic [7:0] vmax,
        input logic [7:0] vmin
    );
        wrap_inc = (v >= vmax) ? vmin : v + 8'h01;
    endfunction

    // years 2000..2099: every fourth year is a leap year
    function automatic logic [7:0] days_in(
        input logic [7:0] m,
        input logic [7:0] y
    );
        if (m == FEB)
            days_in = (y[1:0] == 2'b00) ? DAYS_29 : DAYS_28;
        else if (m == APR || m == JUN || m == SEP || m == NOV)
            days_in = DAYS_30;
        else
            days_in = DAYS_31;
    endfunction

    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_month;
    logic c_year;

    // ------------------------------------------------------------
    // cascade
    // ------------------------------------------------------------
    always_comb
    begin
        c_min   = (cur.sec >= SEC_MAX);
        c_hour  = c_min  && (cur.min >= MIN_MAX);
        c_day   = c_hour && (cur.hour >= HOUR_MAX);
        c_month = c_day  && (cur.dom >= days_in(cur.month, cur.year));
        c_year  = c_month && (cur.month >= MONTH_MAX);
        nxt       = cur;
        nxt.sec   = wrap_inc(cur.sec, SEC_MAX, SEC_RST);
        if (c_min)
            nxt.min = wrap_inc(cur.min, MIN_MAX, MIN_RST);
        if (c_hour)
            nxt.hour = wrap_inc(cur.hour, HOUR_MAX, HOUR_RST);
        if (c_day)
        begin
            nxt.dow = wrap_inc(cur.dow, DOW_MAX, DOW_RST);
            nxt.dom = wrap_inc(cur.dom, days_in(cur.month, cur.year),
                               DOM_RST);
        end
        if (c_month)
            nxt.month = wrap_inc(cur.month, MONTH_MAX, MONTH_RST);
        if (c_year)
            nxt.year = wrap_inc(cur.year, YEAR_MAX, YEAR_RST);
    end

endmodule // calendar_advance

/* File: design/rtc_update_core.sv */
// rtc once-per-second update, alarm, flags and calibration core
//
// Overview of operation
// - one update cycle each second while time base runs and hold is clear
// - hold set aborts an update under way and blocks new ones
// - update increments seconds and carries through to year
// - alarm fires only when seconds, minutes and hours all match
// - all seven counters change on one common second tick
// - alarm compare one slow period after increment ends the update
// - update pending rises 244.1 us before increment, falls at end
// - update done flag set at the end of every update
// - an enable lets its flag drive the combined request, else never
// - enabling an already set flag asserts the request at once
// - flags set on events regardless of enables
// - reading the flag register clears set flags and the request
// - flag read is stable; events during a read post afterwards
// - request, bit 7, high while any flag and enable pair is set
// - programmed alarm recurs daily at the same time
// - calibration off after reset, enable bit switches it
// - untrimmed second is 32768 slow clock periods
// - trimmed second is 32767 when subtracting, 32769 when adding
// - trim count 0..63 seconds adjusted in each 64 second window
// - alarm bytes change only by host writes
// - control bits: update enable 4, alarm enable 5, hold 7
// - flag bits: update done 4, alarm match 5
// - trim count bits 5:0, direction bit 6, enable bit 0
`timescale 1ns/1ps
module rtc_update_core
    import rtc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             slow_clock_input,
    input  wire logic             hold_updates,
    input  wire logic             update_irq_enable,
    input  wire logic             alarm_irq_enable,
    input  wire logic             calibration_enable,
    input  rtc_pkg::trim_t        trim,
    input  wire logic             time_wr,
    input  rtc_pkg::time_t        time_wdata,
    input  wire logic             alarm_wr,
    input  rtc_pkg::alarm_t       alarm_wdata,
    input  wire logic             flags_rd,
    output rtc_pkg::time_t        time_q,
    output rtc_pkg::alarm_t       alarm_q,
    output logic                  update_pending_flag,
    output logic                  update_done_flag,
    output logic                  alarm_match_flag,
    output logic                  combined_request_flag,
    output logic [7:0]            flag_rdata
);

    import rtc_pkg::*;

    // ------------------------------------------------------------
    // slow clock synchroniser and edge detect
    // ------------------------------------------------------------
    logic slow_s1_q;
    logic slow_s2_q;
    logic slow_s3_q;
    logic slow_edge;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            slow_s1_q <= 1'b0;
            slow_s2_q <= 1'b0;
            slow_s3_q <= 1'b0;
        end
        else
        begin
            slow_s1_q <= slow_clock_input;
            slow_s2_q <= slow_s1_q;
            slow_s3_q <= slow_s2_q;
        end
    end

    // one enable pulse per slow period
    assign slow_edge = slow_s2_q & ~slow_s3_q;

    // ------------------------------------------------------------
    // second divider with trim
    // ------------------------------------------------------------
    logic [15:0] div_q;
    logic [5:0]  win_q;
    logic [15:0] sec_len;
    logic        adjust_now;
    logic        sec_tick;
    logic        lead_point;

    // adjusted seconds are the first trim.count of each window
    assign adjust_now = calibration_enable && (win_q < trim.count);

    always_comb
    begin
        sec_len = SECOND_NOMINAL;
        if (adjust_now)
            sec_len = trim.subtract ? SECOND_SHORT : SECOND_LONG;
    end

    assign sec_tick   = slow_edge && !hold_updates
                        && (div_q == sec_len - 16'h0001);
    assign lead_point = slow_edge && !hold_updates
                        && (div_q == sec_len - 16'h0001 - LEAD_SLOW);

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            div_q <= 16'h0000;
        else if (hold_updates)
            div_q <= 16'h0000;
        else if (sec_tick)
            div_q <= 16'h0000;
        else if (slow_edge)
            div_q <= div_q + 16'h0001;
    end

    // 64 second window, wraps on its own width
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            win_q <= 6'h00;
        else if (sec_tick)
            win_q <= win_q + 6'h01;
    end

    // ------------------------------------------------------------
    // update sequencer
    // ------------------------------------------------------------
    upd_state_t  state_q;
    logic [15:0] settle_q;
    logic        compare_now;
    logic        alarm_hit;
    logic        upd_event;
    logic        alm_event;

    assign compare_now = (state_q == ST_SETTLE) && slow_edge
                         && !hold_updates
                         && (settle_q == SETTLE_SLOW - 16'h0001);
    assign alarm_hit = (time_q.sec  == alarm_q.sec)
                    && (time_q.min  == alarm_q.min)
                    && (time_q.hour == alarm_q.hour);
    assign upd_event = compare_now;
    assign alm_event = compare_now && alarm_hit;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q  <= ST_COUNT;
            settle_q <= 16'h0000;
        end
        else if (hold_updates)
        begin
            state_q  <= ST_COUNT;
            settle_q <= 16'h0000;
        end
        else
        begin
            unique case (state_q)
                ST_COUNT:
                begin
                    if (lead_point)
                        state_q <= ST_LEAD;
                end
                ST_LEAD:
                begin
                    settle_q <= 16'h0000;
                    if (sec_tick)
                        state_q <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    if (compare_now)
                        state_q <= ST_COUNT;
                    else if (slow_edge)
                        settle_q <= settle_q + 16'h0001;
                end
            endcase
        end
    end

    // pending flag leads the increment, drops when the compare is done
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            update_pending_flag <= 1'b0;
        else if (hold_updates || compare_now)
            update_pending_flag <= 1'b0;
        else if (lead_point)
            update_pending_flag <= 1'b1;
    end

    // ------------------------------------------------------------
    // time, calendar and alarm bytes
    // ------------------------------------------------------------
    time_t time_next;

    calendar_advance u_advance
    (
        .cur (time_q),
        .nxt (time_next)
    );

    // a host write wins over a tick in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            time_q <= '{year: YEAR_RST, month: MONTH_RST, dom: DOM_RST,
                        dow: DOW_RST, hour: HOUR_RST, min: MIN_RST,
                        sec: SEC_RST};
        else if (time_wr)
            time_q <= time_wdata;
        else if (sec_tick && state_q == ST_LEAD)
            time_q <= time_next;
    end

    // update logic has no path into these bytes
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            alarm_q <= '{hour: ALARM_RST, min: ALARM_RST, sec: ALARM_RST};
        else if (alarm_wr)
            alarm_q <= alarm_wdata;
    end

    // ------------------------------------------------------------
    // flag register, double latched
    // ------------------------------------------------------------
    logic rd_prev_q;
    logic rd_start;
    logic rd_end;
    logic udf_hold_q;
    logic amf_hold_q;

    assign rd_start = flags_rd & ~rd_prev_q;
    assign rd_end   = ~flags_rd & rd_prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            rd_prev_q <= 1'b0;
        else
            rd_prev_q <= flags_rd;
    end

    // events during a read wait here until the read is over
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            udf_hold_q <= 1'b0;
            amf_hold_q <= 1'b0;
        end
        else if (rd_end)
        begin
            udf_hold_q <= 1'b0;
            amf_hold_q <= 1'b0;
        end
        else if (flags_rd)
        begin
            udf_hold_q <= udf_hold_q | upd_event;
            amf_hold_q <= amf_hold_q | alm_event;
        end
    end

    // at read end the read bits clear; held and same-cycle events win
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            update_done_flag <= 1'b0;
            alarm_match_flag <= 1'b0;
        end
        else if (rd_end)
        begin
            update_done_flag <= udf_hold_q | upd_event;
            alarm_match_flag <= amf_hold_q | alm_event;
        end
        else if (!flags_rd)
        begin
            update_done_flag <= update_done_flag | upd_event;
            alarm_match_flag <= alarm_match_flag | alm_event;
        end
    end

    // request follows the enabled flags; reflects enable writes next edge
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            combined_request_flag <= 1'b0;
        else
            combined_request_flag <=
                (update_done_flag && update_irq_enable)
             || (alarm_match_flag && alarm_irq_enable);
    end

    // snapshot taken as the read opens, held steady through it
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            flag_rdata <= 8'h00;
        else if (rd_start)
        begin
            flag_rdata           <= 8'h00;
            flag_rdata[UDF_BIT]  <= update_done_flag;
            flag_rdata[AMF_BIT]  <= alarm_match_flag;
            flag_rdata[COMBINED_REQUEST_FLAG_BIT] <= combined_request_flag;
        end
    end

endmodule // rtc_update_core

/* File: verif/rtc_core_checker_assertions.sv */
// concurrent checks on the ports of the rtc update core
`timescale 1ns/1ps
module rtc_core_checker
    import rtc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       slow_clock_input,
    input wire logic       hold_updates,
    input wire logic       update_irq_enable,
    input wire logic       alarm_irq_enable,
    input wire logic       calibration_enable,
    input rtc_pkg::trim_t  trim,
    input wire logic       time_wr,
    input rtc_pkg::time_t  time_wdata,
    input wire logic       alarm_wr,
    input rtc_pkg::alarm_t alarm_wdata,
    input wire logic       flags_rd,
    input rtc_pkg::time_t  time_q,
    input rtc_pkg::alarm_t alarm_q,
    input wire logic       update_pending_flag,
    input wire logic       update_done_flag,
    input wire logic       alarm_match_flag,
    input wire logic       combined_request_flag,
    input wire logic [7:0] flag_rdata
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // update steps
    // ------------------------------------------------------------
    sequence s_tick;
        time_q != $past(time_q) && !$past(time_wr);
    endsequence

    // compare finished with no hold and no read to park the flags
    sequence s_end_free;
        $fell(update_pending_flag) && !$past(hold_updates)
            && !flags_rd && !$past(flags_rd);
    endsequence

    a_request_sum: assert property (
        combined_request_flag == $past(update_done_flag && update_irq_enable
            || alarm_match_flag && alarm_irq_enable))
        else $error("request flag differs from enabled flags");
    a_read_snapshot: assert property (
        $rose(flags_rd) |=> flag_rdata == {$past(combined_request_flag),
            1'b0, $past(alarm_match_flag), $past(update_done_flag), 4'h0})
        else $error("flag byte snapshot wrong");
    a_read_steady: assert property (
        $past(flags_rd, 2) && $past(flags_rd) |-> $stable(flag_rdata))
        else $error("flag byte moved during read");
    a_events_held: assert property (
        $past(flags_rd, 2) && $past(flags_rd)
            |-> !$rose(update_done_flag) && !$rose(alarm_match_flag))
        else $error("flag posted during read");
    a_alarm_written: assert property (
        !alarm_wr |=> $stable(alarm_q))
        else $error("alarm bytes changed without write");
    a_hold_pending: assert property (
        hold_updates [*2] |-> !update_pending_flag)
        else $error("pending high while held");
    a_hold_time: assert property (
        hold_updates [*2] ##0 !time_wr |=> $stable(time_q))
        else $error("time advanced while held");
    a_tick_pending: assert property (
        s_tick |-> $past(update_pending_flag))
        else $error("time advanced without pending");
    a_done_at_end: assert property (
        s_end_free |-> update_done_flag)
        else $error("update done flag missing");
    a_alarm_cause: assert property (
        s_end_free ##0 (time_q[23:0] == alarm_q) |-> alarm_match_flag)
        else $error("alarm flag missing on match");
    a_alarm_match: assert property (
        $rose(alarm_match_flag) |-> time_q[23:0] == alarm_q)
        else $error("alarm flag without match");
endmodule // rtc_core_checker

bind rtc_update_core rtc_core_checker i_chk (
    .sys_clk, .nrst, .slow_clock_input, .hold_updates, .update_irq_enable,
    .alarm_irq_enable, .calibration_enable, .trim, .time_wr, .time_wdata,
    .alarm_wr, .alarm_wdata, .flags_rd, .time_q, .alarm_q,
    .update_pending_flag, .update_done_flag, .alarm_match_flag,
    .combined_request_flag, .flag_rdata
);

/* File: verif/host_flag_reader.sv */
// host model that reads the flag register for a set number of cycles
`timescale 1ns/1ps
module host_flag_reader (
    input  wire logic       sys_clk,
    input  wire logic       start,
    input  wire logic [7:0] len,
    input  wire logic [7:0] flag_rdata,
    output logic            flags_rd,
    output logic [7:0]      seen
);
    logic [7:0] left_q = 8'h00;

    // one read at a time; a start while busy is ignored
    assign flags_rd = (left_q != 8'h00);

    always_ff @(posedge sys_clk)
    begin
        if (start && !flags_rd)
            left_q <= len;
        else if (flags_rd)
            left_q <= left_q - 8'h01;
    end

    // whole byte kept so the caller looks at every source at once
    always_ff @(posedge sys_clk)
    begin
        if (left_q == 8'h01)
            seen <= flag_rdata;
    end
endmodule // host_flag_reader

/* File: verif/tb_rtc_update_core.sv */
// self-checking bench for the rtc update core
`timescale 1ns/1ps
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_rtc_update_core;
    import rtc_pkg::*;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       slow_clock_input = 1'b0;
    logic       hold_updates = 1'b1;
    logic       update_irq_enable = 1'b0;
    logic       alarm_irq_enable = 1'b0;
    logic       calibration_enable = 1'b0;
    trim_t      trim = '0;
    logic       time_wr = 1'b0;
    time_t      time_wdata = '0;
    logic       alarm_wr = 1'b0;
    alarm_t     alarm_wdata = '0;
    logic       rd_start = 1'b0;
    logic [7:0] rd_len = 8'h03;
    logic       flags_rd;
    logic [7:0] seen;
    time_t      time_q;
    alarm_t     alarm_q;
    logic       update_pending_flag, update_done_flag;
    logic       alarm_match_flag, combined_request_flag;
    logic [7:0] flag_rdata;
    wire  [2:0] flags = {update_done_flag, alarm_match_flag,
                         combined_request_flag};
    int         checks = 0;
    int         miscompares = 0;
    int         cyc = 0;
    int         t_r, t_a, t_b;
    logic [7:0] rnd = 8'h55;

    // slow clock sped up to two system cycles so a second stays short
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    always @(posedge sys_clk) if (nrst) slow_clock_input <= ~slow_clock_input;

    rtc_update_core i_dut (
        .sys_clk, .nrst, .slow_clock_input, .hold_updates, .update_irq_enable,
        .alarm_irq_enable, .calibration_enable, .trim, .time_wr, .time_wdata,
        .alarm_wr, .alarm_wdata, .flags_rd, .time_q, .alarm_q,
        .update_pending_flag, .update_done_flag, .alarm_match_flag,
        .combined_request_flag, .flag_rdata
    );
    host_flag_reader i_host (
        .sys_clk, .start(rd_start), .len(rd_len), .flag_rdata, .flags_rd,
        .seen
    );

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int sec_cycles(input logic c, input logic s);
        return 2 * (c ? (s ? 32767 : 32769) : 32768);
    endfunction
    function automatic logic [7:0] flag_byte(input logic r, a, u);
        return {r, 1'b0, a, u, 4'h0};
    endfunction
    task automatic pause(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic tick(output int at);
        time_t t0;
        t0 = time_q;
        for (int k = 0; k < 70000 && time_q === t0; k++)
            @(posedge sys_clk);
        at = cyc;
    endtask
    task automatic host_read(input logic [7:0] len);
        rd_len   <= len;
        rd_start <= 1'b1;
        @(posedge sys_clk);
        rd_start <= 1'b0;
        pause(int'(len) + 4);
    endtask
    task automatic conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        pause(12);
        nrst <= 1'b1;
        pause(3);
        `CHECK({flags, flag_rdata}, 11'h000)
        rnd = lfsr(rnd);
        // trim forced on so the timed second exercises the trim path
        calibration_enable <= 1'b1;
        trim <= {rnd[0], 1'b1, rnd[5:1]};
        time_wdata <= {8'h63, 8'h0c, 8'h1f, 8'h07, 8'h17, 8'h3b, 8'h3b};
        time_wr <= 1'b1;
        alarm_wr <= 1'b1;
        pause(1);
        time_wr <= 1'b0;
        alarm_wr <= 1'b0;
        pause(3);
        `CHECK(time_q, 56'h630c1f07173b3b)
        hold_updates <= 1'b0;
        t_r = cyc;
        tick(t_a);
        `CHECK(time_q, 56'h00010101000000)
        `CHECK((t_a - t_r) >= sec_cycles(calibration_enable, trim.subtract) - 16
            && (t_a - t_r) <= sec_cycles(calibration_enable,
            trim.subtract) + 16, 1'b1)
        pause(6);
        `CHECK({update_pending_flag, flags}, 4'b0110)
        `CHECK(alarm_q, 24'h000000)
        for (int i = 0; i < 4; i++)
        begin
            {update_irq_enable, alarm_irq_enable} <= i[1:0];
            pause(3);
            `CHECK(combined_request_flag, i != 0)
        end
        alarm_irq_enable <= 1'b0;
        rnd = lfsr(rnd);
        host_read(8'h02 + {5'h00, rnd[2:0]});
        `CHECK(seen, flag_byte(1'b1, 1'b1, 1'b1))
        `CHECK(flags, 3'b000)
        // read held across the whole update to catch lost events
        fork
            tick(t_b);
            begin
                while (update_pending_flag !== 1'b1)
                    @(posedge sys_clk);
                host_read(8'h30);
            end
        join
        pause(2);
        `CHECK(seen, 8'h00)
        `CHECK(flags, 3'b101)
        `CHECK(time_q, 56'h00010101000001)
        `CHECK(t_b - t_a, sec_cycles(calibration_enable,
            trim.subtract))
        conclude();
    end

    initial
    begin
        pause(150000);
        miscompares++;
        conclude();
    end
endmodule // tb_rtc_update_core
